// file: design/rps_consts.svh
// constants for the reset and power saving sequencer
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH
`define RPS_LONG_DELAY       1000000
`define RPS_SHORT_DELAY      4096
`define RPS_BOD_FILTER       100
`define RPS_CNT_W            20
`define RPS_FLT_W            7
`define RPS_CONF_W           8
`define RPS_CONF_RESET       8'h00
`define RPS_BROWNOUT_EN_BIT  7
`define RPS_CONF_BOD_KEEP    8'h80
`define RPS_EXT_UNMASK_BIT   0
`define RPS_BOOT_ADDR        16'h0000
`define RPS_BOOT_BYTES       2'h3
`endif

// file: design/rps_pkg.sv
// types for the reset and power saving sequencer
package rps_pkg;
	typedef enum logic [2:0] {
		RPS_RESET = 3'b000,
		RPS_RUN   = 3'b001,
		RPS_WAIT  = 3'b011,
		RPS_HALT  = 3'b010,
		RPS_WAKE  = 3'b110
	} rps_state_e;
endpackage

// file: design/rps_delay_counter.sv
// reloadable down counter for the reset and wake-up delays
`timescale 1ns/1ps
`include "rps_consts.svh"
module rps_delay_counter #(
	parameter int W = `RPS_CNT_W
) (
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_count,
	input  wire logic         i_run,
	output logic              o_done
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	wire          at_zero = (cnt_q == '0);

	// a load always restarts from the full count
	assign cnt_d  = i_load ? i_count : ((i_run && !at_zero) ? cnt_q - W'(1) : cnt_q);
	assign o_done = at_zero && !i_load;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// file: design/rps_bod_filter.sv
// persistence filter on the brown-out detector output
`timescale 1ns/1ps
`include "rps_consts.svh"
module rps_bod_filter #(
	parameter int LEN = `RPS_BOD_FILTER,
	parameter int W   = `RPS_FLT_W
) (
	input  wire logic i_clk,
	input  wire logic i_rstn,
	input  wire logic i_enable,
	input  wire logic i_raw_low,
	output logic      o_low
);
	logic [W-1:0] run_q;
	logic [W-1:0] run_d;
	logic         low_q;
	logic         low_d;
	wire          differs = i_enable && (i_raw_low != low_q);
	wire          expired = (run_q == W'(LEN));

	// state flips only after the input differed for more than LEN cycles
	assign run_d = (!differs || expired) ? '0 : run_q + W'(1);
	assign low_d = !i_enable ? 1'b0 : ((differs && expired) ? i_raw_low : low_q);
	assign o_low = low_q;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			run_q <= '0;
			low_q <= 1'b0;
		end else begin
			run_q <= run_d;
			low_q <= low_d;
		end
	end
endmodule

// file: design/rps_sequencer.sv
// reset merge, reset release timing and wait/halt control
`timescale 1ns/1ps
`include "rps_consts.svh"
module rps_sequencer
	import rps_pkg::*;
#(
	parameter int LONG_DELAY  = `RPS_LONG_DELAY,
	parameter int SHORT_DELAY = `RPS_SHORT_DELAY,
	parameter int BOD_FILTER  = `RPS_BOD_FILTER
) (
	input  wire logic                   I_REF_CLK,
	input  wire logic                   I_RSTN,
	input  wire logic                   I_POR_RELEASE,
	input  wire logic                   I_RESET_PIN,
	input  wire logic                   I_WATCHDOG_RESET,
	input  wire logic                   I_WATCHDOG_ENABLED,
	input  wire logic                   I_BROWNOUT_DETECTOR_LOW,
	input  wire logic                   I_CONF_WE,
	input  wire logic [`RPS_CONF_W-1:0] I_CONF_WDATA,
	input  wire logic                   I_WAIT_INSTR,
	input  wire logic                   I_HALT_INSTR,
	input  wire logic                   I_ANY_IRQ,
	input  wire logic                   I_EXT_IRQ,
	output logic                        O_CORE_RESET,
	output logic [`RPS_CONF_W-1:0]      O_INTERRUPT_MASK_CONFIG,
	output logic                        O_CPU_STALL,
	output logic                        O_OSC_ENABLE,
	output logic                        O_PERIPH_CLK_EN,
	output logic                        O_HALT_SKIPPED,
	output logic                        O_RESUME_EXT_ISR,
	output logic                        O_RESUME_LOW_ISR,
	output logic                        O_BOOT_FETCH,
	output logic [15:0]                 O_BOOT_ADDR,
	output logic [1:0]                  O_BOOT_LEN
);
	localparam int CW = `RPS_CNT_W;

	////////////////////////////////////////////////////////////////////////////
	// reset sources and brown-out
	rps_state_e   state_q;
	rps_state_e   state_d;
	logic         por_q;
	logic [`RPS_CONF_W-1:0] conf_q;
	logic [`RPS_CONF_W-1:0] conf_d;
	logic         was_bod_q;
	logic         wake_rst_q;
	logic         boot_q;
	logic         ext_wake_q;
	logic         ext_res_q;
	logic         low_res_q;
	logic         skip_q;
	logic         bod_low;
	logic         dly_done;

	// por detection active from power-up, no software enable
	wire por_edge   = I_POR_RELEASE && !por_q;
	// pin is input only; internal resets never touch it
	wire ext_rst    = !I_RESET_PIN;
	wire bod_en     = conf_q[`RPS_BROWNOUT_EN_BIT] && (state_q != RPS_HALT);
	wire bod_rise   = was_bod_q && !bod_low;
	wire long_evt   = por_edge || ext_rst || I_WATCHDOG_RESET;
	wire halt_ok    = I_HALT_INSTR && !I_WATCHDOG_ENABLED && state_q == RPS_RUN;
	wire wake_load  = state_q == RPS_HALT && (I_EXT_IRQ || ext_rst);
	// any new event reloads; long delay wins over short
	wire dly_load   = long_evt || bod_rise || wake_load;
	wire [CW-1:0] dly_count = (long_evt || (wake_load && ext_rst)) ? CW'(LONG_DELAY) :
		CW'(SHORT_DELAY);
	wire in_reset   = state_q == RPS_RESET || (state_q == RPS_WAKE && wake_rst_q);
	wire core_rst   = in_reset || bod_low || long_evt;

	rps_bod_filter #(
		.LEN (BOD_FILTER),
		.W   (`RPS_FLT_W)
	) u_bod (
		.i_clk     (I_REF_CLK),
		.i_rstn    (I_RSTN),
		.i_enable  (bod_en),
		.i_raw_low (I_BROWNOUT_DETECTOR_LOW),
		.o_low     (bod_low)
	);

	rps_delay_counter #(
		.W (CW)
	) u_dly (
		.i_clk   (I_REF_CLK),
		.i_rstn  (I_RSTN),
		.i_load  (dly_load),
		.i_count (dly_count),
		.i_run   (!bod_low),
		.o_done  (dly_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// mode state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			RPS_RESET: begin
				if (dly_done && !bod_low && !long_evt) begin
					state_d = RPS_RUN;
				end
			end
			RPS_RUN: begin
				if (halt_ok) begin
					state_d = RPS_HALT;
				end else if (I_WAIT_INSTR) begin
					state_d = RPS_WAIT;
				end
			end
			RPS_WAIT: begin
				if (I_ANY_IRQ) begin
					state_d = RPS_RUN;
				end
			end
			RPS_HALT: begin
				if (wake_load) begin
					state_d = RPS_WAKE;
				end
			end
			RPS_WAKE: begin
				if (dly_done && !long_evt) begin
					state_d = wake_rst_q ? RPS_RESET : RPS_RUN;
				end
			end
			default: begin
				state_d = RPS_RESET;
			end
		endcase
		// reset from any mode but halt goes straight back to the reset delay
		if ((long_evt && state_q != RPS_HALT) || bod_low) begin
			state_d = RPS_RESET;
		end
	end

	// every reset clears config, but a brown-out reset spares its own enable
	// bit, else the detector would switch itself off and end its reset early
	wire [`RPS_CONF_W-1:0] conf_rst_val = long_evt ? `RPS_CONF_RESET : (conf_q & `RPS_CONF_BOD_KEEP);
	assign conf_d = core_rst ? conf_rst_val : (I_CONF_WE ? I_CONF_WDATA : conf_q);

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			state_q <= RPS_RESET;
			por_q   <= 1'b0;
			conf_q  <= `RPS_CONF_RESET;
		end else begin
			state_q <= state_d;
			por_q   <= I_POR_RELEASE;
			conf_q  <= conf_d;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			was_bod_q  <= 1'b0;
			wake_rst_q <= 1'b0;
			boot_q     <= 1'b0;
			ext_wake_q <= 1'b0;
		end else begin
			was_bod_q  <= bod_low;
			wake_rst_q <= wake_load ? ext_rst : (state_q == RPS_WAKE ? wake_rst_q : 1'b0);
			// core reset is still up in the leaving cycle, so it cannot gate this
			boot_q     <= state_q == RPS_RESET && state_d == RPS_RUN;
			ext_wake_q <= wake_load && I_EXT_IRQ && !ext_rst ? 1'b1 :
				(state_q == RPS_WAKE ? ext_wake_q : 1'b0);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// resume pulses after halt wake
	wire wake_done = state_q == RPS_WAKE && state_d == RPS_RUN && ext_wake_q;
	wire ext_mask  = conf_q[`RPS_EXT_UNMASK_BIT];

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ext_res_q <= 1'b0;
			low_res_q <= 1'b0;
			skip_q    <= 1'b0;
		end else begin
			ext_res_q <= wake_done && ext_mask;
			low_res_q <= wake_done && !ext_mask;
			skip_q    <= I_HALT_INSTR && I_WATCHDOG_ENABLED && state_q == RPS_RUN;
		end
	end

	assign O_CORE_RESET            = core_rst;
	assign O_INTERRUPT_MASK_CONFIG = conf_q;
	// wait keeps clocks running; only the core is parked
	assign O_CPU_STALL             = state_q != RPS_RUN;
	// oscillator off in halt; restarted at wake
	assign O_OSC_ENABLE            = state_q != RPS_HALT;
	assign O_PERIPH_CLK_EN         = state_q != RPS_HALT;
	assign O_HALT_SKIPPED          = skip_q;
	assign O_RESUME_EXT_ISR        = ext_res_q;
	assign O_RESUME_LOW_ISR        = low_res_q;
	assign O_BOOT_FETCH            = boot_q;
	assign O_BOOT_ADDR             = `RPS_BOOT_ADDR;
	assign O_BOOT_LEN              = `RPS_BOOT_BYTES;

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_ext_reset_now;
		@(posedge I_REF_CLK) disable iff (!I_RSTN) !I_RESET_PIN |-> O_CORE_RESET;
	endproperty
	a_ext_reset_now: assert property (p_ext_reset_now) else $error("external reset not immediate");

	property p_bod_holds;
		@(posedge I_REF_CLK) disable iff (!I_RSTN) bod_low |=> O_CORE_RESET [*8];
	endproperty
	a_bod_holds: assert property (p_bod_holds) else $error("reset released during brown-out");

	property p_bod_keep;
		@(posedge I_REF_CLK) disable iff (!I_RSTN) bod_low && bod_en && !long_evt |=> conf_q[`RPS_BROWNOUT_EN_BIT];
	endproperty
	a_bod_keep: assert property (p_bod_keep) else $error("brown-out reset disabled its own detector");

	property p_long_hold;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
			long_evt && !bod_low && state_q != RPS_HALT |=> O_CORE_RESET [*8];
	endproperty
	a_long_hold: assert property (p_long_hold) else $error("long reset released early");

	property p_halt_stays;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
			state_q == RPS_HALT && !I_EXT_IRQ && I_RESET_PIN |=> state_q == RPS_HALT;
	endproperty
	a_halt_stays: assert property (p_halt_stays) else $error("halt left without wake source");

	property p_boot_pulse;
		@(posedge I_REF_CLK) disable iff (!I_RSTN) state_q == RPS_RESET ##1 state_q == RPS_RUN |-> O_BOOT_FETCH;
	endproperty
	a_boot_pulse: assert property (p_boot_pulse) else $error("no boot fetch after reset");

	property p_halt_osc;
		@(posedge I_REF_CLK) disable iff (!I_RSTN) state_q == RPS_HALT |-> !O_OSC_ENABLE && !bod_en;
	endproperty
	a_halt_osc: assert property (p_halt_osc) else $error("halt with oscillator or brown-out on");

	property p_halt_skip;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
			state_q == RPS_RUN && I_HALT_INSTR && I_WATCHDOG_ENABLED && !long_evt && !bod_low
			|=> state_q != RPS_HALT && O_HALT_SKIPPED;
	endproperty
	a_halt_skip: assert property (p_halt_skip) else $error("halt taken with watchdog on");

	property p_wait_clocks;
		@(posedge I_REF_CLK) disable iff (!I_RSTN) state_q == RPS_WAIT |-> O_CPU_STALL && O_PERIPH_CLK_EN;
	endproperty
	a_wait_clocks: assert property (p_wait_clocks) else $error("wait mode clocks wrong");

	property p_wait_exit;
		@(posedge I_REF_CLK) disable iff (!I_RSTN) state_q == RPS_WAIT && I_ANY_IRQ |=> state_q != RPS_WAIT;
	endproperty
	a_wait_exit: assert property (p_wait_exit) else $error("wait not left on interrupt");

	property p_enter_mode;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
			state_q == RPS_RUN && !I_WAIT_INSTR && !I_HALT_INSTR |=> state_q != RPS_WAIT && state_q != RPS_HALT;
	endproperty
	a_enter_mode: assert property (p_enter_mode) else $error("low power mode without instruction");

	property p_conf_reset;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
			O_CORE_RESET |=> O_INTERRUPT_MASK_CONFIG[`RPS_BROWNOUT_EN_BIT-1:0] == '0;
	endproperty
	a_conf_reset: assert property (p_conf_reset) else $error("config not cleared by reset");

	property p_conf_long;
		@(posedge I_REF_CLK) disable iff (!I_RSTN) long_evt |=> O_INTERRUPT_MASK_CONFIG == `RPS_CONF_RESET;
	endproperty
	a_conf_long: assert property (p_conf_long) else $error("config not cleared by long reset");

	property p_short_release;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
			state_q == RPS_HALT && I_EXT_IRQ && I_RESET_PIN |=> state_q == RPS_WAKE && !O_CORE_RESET;
	endproperty
	a_short_release: assert property (p_short_release) else $error("interrupt wake wrong");

	c_wait:  cover property (@(posedge I_REF_CLK) disable iff (!I_RSTN) state_q == RPS_WAIT ##1 state_q == RPS_RUN);
	c_halt:  cover property (@(posedge I_REF_CLK) disable iff (!I_RSTN) state_q == RPS_WAKE ##1 state_q == RPS_RUN);
	c_bod:   cover property (@(posedge I_REF_CLK) disable iff (!I_RSTN) $fell(bod_low));
	c_boot:  cover property (@(posedge I_REF_CLK) disable iff (!I_RSTN) O_BOOT_FETCH);
	c_hrst:  cover property (@(posedge I_REF_CLK) disable iff (!I_RSTN) state_q == RPS_WAKE && wake_rst_q);
endmodule

// file: dv/rps_supply_model.sv
// behavioural model of the reset pin and the supply detectors
`timescale 1ns/1ps
module rps_supply_model (
	input  wire logic i_pin_low_req,
	input  wire logic i_supply_good,
	input  wire logic i_supply_dip,
	output logic      o_reset_pin,
	output logic      o_por_release,
	output logic      o_bod_low
);
	// pull-up holds the pin high unless the board pulls it low
	assign o_reset_pin   = i_pin_low_req ? 1'b0 : 1'b1;
	// detector starts low at power-up, no set-up needed
	assign o_por_release = i_supply_good;
	assign o_bod_low     = i_supply_dip;
endmodule

// file: dv/tb_top.sv
// self-checking bench for the reset and power saving sequencer
`timescale 1ns/1ps
module tb_top;
	localparam int LONG = 50;
	localparam int SHORT = 20;
	localparam int FLT = 5;
	logic       clk = 1'b0, rstn = 1'b0, pin_req = 1'b0, good = 1'b0, dip = 1'b0;
	logic       wd_rst = 1'b0, wd_en = 1'b0, we = 1'b0, wt = 1'b0, ht = 1'b0, any_irq = 1'b0, ext_irq = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic       pin, por, bod, core_rst, stall, osc, periph, skipped, ext_isr, low_isr, boot, b0;
	logic [7:0] conf;
	logic [15:0] baddr;
	logic [1:0] blen;
	int         bad_count = 0, comparisons = 0, cycles = 0, n;

	always #4 clk = ~clk;

	rps_supply_model u_rps_supply_model (.i_pin_low_req(pin_req), .i_supply_good(good), .i_supply_dip(dip),
		.o_reset_pin(pin), .o_por_release(por), .o_bod_low(bod));

	rps_sequencer #(.LONG_DELAY(LONG), .SHORT_DELAY(SHORT), .BOD_FILTER(FLT)) u_rps_sequencer (
		.I_REF_CLK(clk), .I_RSTN(rstn), .I_POR_RELEASE(por), .I_RESET_PIN(pin),
		.I_WATCHDOG_RESET(wd_rst), .I_WATCHDOG_ENABLED(wd_en), .I_BROWNOUT_DETECTOR_LOW(bod),
		.I_CONF_WE(we), .I_CONF_WDATA(wdata), .I_WAIT_INSTR(wt), .I_HALT_INSTR(ht),
		.I_ANY_IRQ(any_irq), .I_EXT_IRQ(ext_irq), .O_CORE_RESET(core_rst), .O_INTERRUPT_MASK_CONFIG(conf),
		.O_CPU_STALL(stall), .O_OSC_ENABLE(osc), .O_PERIPH_CLK_EN(periph), .O_HALT_SKIPPED(skipped),
		.O_RESUME_EXT_ISR(ext_isr), .O_RESUME_LOW_ISR(low_isr), .O_BOOT_FETCH(boot),
		.O_BOOT_ADDR(baddr), .O_BOOT_LEN(blen));

	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (bad_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int lo, input int hi);
		comparisons++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, lo);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	// bounded so a stuck output cannot hang the run
	task automatic until_low(input bit sel, input int lim, output int k);
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (((sel ? stall : core_rst) !== 1'b0) && k < lim);
	endtask

	task automatic wr_conf(input logic [7:0] v);
		cyc(1);
		we <= 1'b1;
		wdata <= v;
		cyc(1);
		we <= 1'b0;
		#1;
		chk_vec(conf, v);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_por;
		cyc(1);
		good <= 1'b1;
		#1;
		chk_vec(core_rst, 1'b1);
		until_low(0, LONG + 10, n);
		chk_cnt(n, LONG - 1, LONG + 3);
		b0 = boot;
		cyc(1);
		#1;
		chk_vec(b0 | boot, 1'b1);
		chk_vec(baddr, 16'h0000);
		chk_vec(blen, 2'h3);
	endtask

	// src 0 pulls the pin, src 1 fires the watchdog; second event mid-count
	task automatic t_long_src(input bit src);
		wr_conf(8'h81);
		repeat (2) begin
			cyc(1);
			if (src) wd_rst <= 1'b1; else pin_req <= 1'b1;
			#1;
			chk_vec(core_rst, 1'b1);
			cyc(1);
			wd_rst <= 1'b0;
			pin_req <= 1'b0;
			cyc(LONG / 2);
		end
		#1;
		chk_vec(conf, 8'h00);
		until_low(0, LONG + 10, n);
		chk_cnt(n, LONG / 2 - 1, LONG / 2 + 3);
	endtask

	task automatic t_bod;
		cyc(1);
		dip <= 1'b1;
		cyc(3 * FLT);
		#1;
		chk_vec(core_rst, 1'b0);
		cyc(1);
		dip <= 1'b0;
		cyc(3 * FLT);
		wr_conf(8'h80);
		cyc(1);
		dip <= 1'b1;
		cyc(FLT);
		dip <= 1'b0;
		cyc(3);
		#1;
		chk_vec(core_rst, 1'b0);
		cyc(1);
		dip <= 1'b1;
		cyc(FLT + 4);
		#1;
		chk_vec(core_rst, 1'b1);
		cyc(2 * SHORT);
		#1;
		chk_vec(core_rst, 1'b1);
		cyc(1);
		dip <= 1'b0;
		until_low(0, 100, n);
		chk_cnt(n, SHORT, SHORT + FLT + 4);
		chk_vec(conf, 8'h80);
	endtask

	task automatic t_wait;
		#1;
		chk_vec(stall, 1'b0);
		cyc(1);
		wt <= 1'b1;
		cyc(1);
		wt <= 1'b0;
		cyc(2);
		#1;
		chk_vec({stall, osc, periph}, 3'h7);
		cyc(1);
		any_irq <= 1'b1;
		until_low(1, 5, n);
		chk_cnt(n, 1, 3);
		cyc(1);
		any_irq <= 1'b0;
	endtask

	// unmask picks which resume routine must follow the wake
	task automatic t_halt(input bit unmask);
		wr_conf({7'h00, unmask});
		cyc(1);
		ht <= 1'b1;
		wd_en <= 1'b1;
		cyc(1);
		ht <= 1'b0;
		#1;
		b0 = skipped;
		cyc(1);
		#1;
		chk_vec({b0 | skipped, stall}, 2'h2);
		cyc(1);
		wd_en <= 1'b0;
		ht <= 1'b1;
		cyc(1);
		ht <= 1'b0;
		cyc(2);
		any_irq <= 1'b1;
		cyc(3);
		#1;
		chk_vec({osc, periph, stall}, 3'h1);
		cyc(1);
		ext_irq <= 1'b1;
		cyc(1);
		ext_irq <= 1'b0;
		any_irq <= 1'b0;
		#1;
		chk_vec(osc, 1'b1);
		until_low(1, SHORT + 10, n);
		chk_cnt(n, SHORT - 1, SHORT + 3);
		b0 = unmask ? ext_isr : low_isr;
		cyc(1);
		#1;
		chk_vec(b0 | (unmask ? ext_isr : low_isr), 1'b1);
	endtask

	// reset pin pulled while halted: long delay, then a fresh boot
	task automatic t_halt_rst;
		wr_conf(8'h01);
		cyc(1);
		ht <= 1'b1;
		cyc(1);
		ht <= 1'b0;
		cyc(2);
		pin_req <= 1'b1;
		cyc(1);
		pin_req <= 1'b0;
		#1;
		chk_vec({osc, core_rst}, 2'h3);
		chk_vec(conf, 8'h00);
		until_low(0, LONG + 10, n);
		chk_cnt(n, LONG - 1, LONG + 3);
		chk_vec(boot, 1'b1);
	endtask

	// own power reset mid-run; a supply already good counts as a fresh power-on
	task automatic t_rstn;
		wr_conf(8'h81);
		cyc(1);
		rstn <= 1'b0;
		cyc(2);
		rstn <= 1'b1;
		#1;
		chk_vec({conf, core_rst}, 9'h001);
		until_low(0, LONG + 10, n);
		chk_cnt(n, LONG - 1, LONG + 3);
	endtask

	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			end_of_test();
		end
	end

	initial begin
		cyc(12);
		rstn <= 1'b1;
		t_por();
		t_long_src(1'b0);
		t_long_src(1'b1);
		t_bod();
		t_wait();
		t_halt(1'b1);
		t_halt(1'b0);
		t_halt_rst();
		t_rstn();
		end_of_test();
	end
endmodule
